// ### tmsv_pkg.sv
/*
   Constants of the bus timeout supervisor: slots, groups, resets, idle time.
   Assumes one core clock at CLK_HZ; limits are in core cycles.
*/
package tmsv_pkg;
   // clock and idle time
   localparam int CLK_HZ    = 20_000_000;
   localparam int IDLE_US   = 50;
   localparam int IDLE_CYC  = IDLE_US * (CLK_HZ / 1_000_000);
   localparam int IDLE_W    = 16;
   // timer slots
   localparam int TMR_W     = 16;
   localparam int TMR_NUM   = 5;
   localparam int T_CLK_LOW = 0;
   localparam int T_ARB     = 1;
   localparam int T_BYTE    = 2;
   localparam int T_TRANS   = 3;
   localparam int T_BOOT    = 4;
   // grouped status bits
   localparam int ST_NUM      = 4;
   localparam int ST_SLV_FAIL = 0;
   localparam int ST_MST_TMO  = 1;
   localparam int ST_MST_ARB  = 2;
   localparam int ST_BOOT     = 3;
   // event slots
   localparam int EV_NUM     = 8;
   localparam int EV_S_CLK   = 0;
   localparam int EV_M_CLK   = 1;
   localparam int EV_M_ARB   = 2;
   localparam int EV_M_BYTE  = 3;
   localparam int EV_S_BYTE  = 4;
   localparam int EV_M_TRANS = 5;
   localparam int EV_S_TRANS = 6;
   localparam int EV_BOOT    = 7;
   // reset values
   localparam logic              LINE_RST = 1'b1;
   localparam logic [ST_NUM-1:0] STAT_RST = 4'h0;
   localparam logic [EV_NUM-1:0] EV_RST   = 8'h00;
endpackage

// ### tmsv_tmr_if.sv
/*
   Supervisor to timeout counter carrier.
   Assumes one core clock at both ends.
*/
`timescale 1ns/10ps
interface tmsv_tmr_if #(parameter int W = 16) ();
   logic         run;
   logic         clr;
   logic [W-1:0] limit;
   logic         expire;
   modport timer (input run, input clr, input limit, output expire);
   modport ctrl  (output run, output clr, output limit, input expire);
endinterface

// ### tmsv_timer.sv
/*
   One timeout counter on the core clock.
   Assumes clr and run come from logic on the same clock.
*/
`timescale 1ns/10ps
module tmsv_timer #(
   parameter int W = 16
) (
   input wire logic   i_clk,
   input wire logic   i_rst_b,
   tmsv_tmr_if.timer  tif
);
   logic [W-1:0] cnt_reg;
   logic         done_reg;
   logic         exp_reg;

   // zero limit disables; after expiry the count parks until clr,
   // so one expiry gives one pulse
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         cnt_reg  <= '0;
         done_reg <= 1'b0;
         exp_reg  <= 1'b0;
      end else if (tif.clr) begin
         cnt_reg  <= '0;
         done_reg <= 1'b0;
         exp_reg  <= 1'b0;
      end else if (tif.run && !done_reg && (tif.limit != '0)) begin
         if (cnt_reg == tif.limit - W'(1)) begin
            cnt_reg  <= '0;
            done_reg <= 1'b1;
            exp_reg  <= 1'b1;
         end else begin
            cnt_reg  <= cnt_reg + W'(1);
            exp_reg  <= 1'b0;
         end
      end else begin
         exp_reg <= 1'b0;
      end
   end

   assign tif.expire = exp_reg;
endmodule

// ### tmsv_supervisor.sv
/*
   Timeout supervisor for a two-wire bus controller: five timers, events,
   grouped status with read snapshot, and abort/stop/release requests.
   Assumes engines on I_CLK give one-cycle phase pulses; bus lines are async.
*/
`timescale 1ns/10ps

// Functional notes
// - Clock-low timer detects the clock line held low too long.
// - Clock-low expiry sets slave or master event, updating its status group.
// - Clock-low expiry aborts without stop, releases lines, engines monitor idle.
// - Arbitration timer only runs for software-started master transactions.
// - Arbitration timer stops once start, address and direction sent cleanly.
// - Ownership lost after address phase aborts the transaction, no retry.
// - Collision in start/address/direction retries after idle; timer keeps running.
// - Arbitration expiry while waiting idle aborts and sets arbitration event.
// - Expiry during address: finish address; acknowledge received means carry on.
// - Expired, then collision during address: abort right after that bit.
// - Byte timeout disabled after reset; flags slow per-byte transfers.
// - Master byte expiry: clock to next driven bit, stop, abort, event.
// - Slave byte expiry: at next bit start release lines, event, resume.
// - Transaction timeout disabled after reset; measures start to stop.
// - Transaction expiry acts like byte expiry with transaction events.
// - Boot expiry: read to next data byte, stop, set boot event.
// - Boot-complete output asserts on boot expiry and on normal completion.
// - Zero boot timer count disables the boot timeout.
// - Interrupt request per status bit only when its enable is set.
// - Write-one clears status only after a read; test set forces one.
// - Both lines high past idle-detect time counts as bus idle.
module tmsv_supervisor #(
   parameter int TW = tmsv_pkg::TMR_W
) (
   input  wire logic                        I_CLK,
   input  wire logic                        I_RST_B,
   input  wire logic                        I_SCL,
   input  wire logic                        I_SERIAL_DATA_LINE,
   input  wire logic                        I_CLK_LOW_EN,
   input  wire logic [TW-1:0]               I_CLK_LOW_LIMIT,
   input  wire logic [TW-1:0]               I_ARB_LIMIT,
   input  wire logic                        I_BYTE_EN,
   input  wire logic [TW-1:0]               I_BYTE_LIMIT,
   input  wire logic                        I_TRANS_EN,
   input  wire logic [TW-1:0]               I_TRANS_LIMIT,
   input  wire logic [TW-1:0]               I_BOOT_DIAG_TIMER_COUNT,
   input  wire logic                        I_MST_ACTIVE,
   input  wire logic                        I_SLV_ACTIVE,
   input  wire logic                        I_SW_START,
   input  wire logic                        I_ADDR_PHASE_DONE,
   input  wire logic                        I_ADDR_SENDING,
   input  wire logic                        I_ADDR_ACK_RX,
   input  wire logic                        I_ARB_COLLIDE,
   input  wire logic                        I_MST_WAIT_IDLE,
   input  wire logic                        I_MST_OWN_LOST,
   input  wire logic                        I_BYTE_DONE,
   input  wire logic                        I_MST_DRIVE_BIT,
   input  wire logic                        I_BIT_START,
   input  wire logic                        I_BOOT_ACTIVE,
   input  wire logic                        I_BOOT_DONE,
   input  wire logic                        I_BOOT_BYTE_DONE,
   input  wire logic                        I_STAT_RD,
   input  wire logic [tmsv_pkg::ST_NUM-1:0] I_STAT_W1C,
   input  wire logic [tmsv_pkg::ST_NUM-1:0] I_STAT_SET,
   input  wire logic [tmsv_pkg::ST_NUM-1:0] I_INT_EN,
   output logic                             O_MST_ABORT,
   output logic                             O_MST_STOP_REQ,
   output logic                             O_MST_RETRY,
   output logic                             O_SLV_RELEASE,
   output logic                             O_LINES_RELEASE,
   output logic                             O_BOOT_STOP_REQ,
   output logic                             O_BOOT_COMPLETE,
   output logic                             O_BUS_IDLE,
   output logic                             O_SLAVE_CLK_LOW_TIMEOUT_EVENT,
   output logic                             O_MASTER_CLK_LOW_TIMEOUT_EVENT,
   output logic                             O_MASTER_ARB_TIMEOUT_EVENT,
   output logic                             O_MASTER_BYTE_TIMEOUT_EVENT,
   output logic                             O_SLAVE_BYTE_TIMEOUT_EVENT,
   output logic                             O_MASTER_TRANSACTION_TIMEOUT_EVENT,
   output logic                             O_SLAVE_TRANSACTION_TIMEOUT_EVENT,
   output logic                             O_BOOT_TIMEOUT_EVENT,
   output logic                             O_SLAVE_ACCESS_FAIL_STATUS,
   output logic                             O_MASTER_TIMEOUT_STATUS,
   output logic                             O_MASTER_ARB_TIMEOUT_STATUS,
   output logic                             O_BOOT_LOAD_FAIL_STATUS,
   output logic [tmsv_pkg::ST_NUM-1:0]      O_IRQ
);
   localparam int SN = tmsv_pkg::ST_NUM;
   localparam int EN = tmsv_pkg::EV_NUM;

   logic                         scl_m_reg, scl_s_reg, scl_d_reg;
   logic                         sda_m_reg, sda_s_reg, sda_d_reg;
   logic                         start_det, stop_det;
   logic [tmsv_pkg::IDLE_W-1:0]  idle_cnt_reg;
   logic                         idle_reg;
   logic                         busy_reg;
   logic [tmsv_pkg::TMR_NUM-1:0] tmr_exp;
   logic                         arb_run_reg, arb_pend_reg, arb_fire;
   logic                         clk_low_fire;
   logic [1:0]                   mst_pend_reg, slv_pend_reg;
   logic                         mst_fire, slv_fire;
   logic                         boot_pend_reg, boot_fire;
   logic [EN-1:0]                ev_next, ev_reg;
   logic [SN-1:0]                hit;
   logic [SN-1:0]                new_reg, snap_reg, new_next, snap_next;
   logic [SN-1:0]                stat_reg, irq_reg;
   logic                         abort_reg, stop_reg, retry_reg;
   logic                         slv_rel_reg, lines_rel_reg, boot_stop_reg, boot_cpl_reg;

   tmsv_tmr_if #(.W(TW)) tif [tmsv_pkg::TMR_NUM] ();

   // three flops on each bus line
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         scl_m_reg <= tmsv_pkg::LINE_RST;
         scl_s_reg <= tmsv_pkg::LINE_RST;
         scl_d_reg <= tmsv_pkg::LINE_RST;
         sda_m_reg <= tmsv_pkg::LINE_RST;
         sda_s_reg <= tmsv_pkg::LINE_RST;
         sda_d_reg <= tmsv_pkg::LINE_RST;
      end else begin
         scl_m_reg <= I_SCL;
         scl_s_reg <= scl_m_reg;
         scl_d_reg <= scl_s_reg;
         sda_m_reg <= I_SERIAL_DATA_LINE;
         sda_s_reg <= sda_m_reg;
         sda_d_reg <= sda_s_reg;
      end
   end

   // start/stop: data edge while clock high
   assign start_det = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
   assign stop_det  = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;

   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         idle_cnt_reg <= '0;
         idle_reg     <= 1'b0;
      end else if (scl_s_reg && sda_s_reg) begin
         if (idle_cnt_reg == tmsv_pkg::IDLE_W'(tmsv_pkg::IDLE_CYC - 1)) begin
            idle_reg <= 1'b1;
         end else begin
            idle_cnt_reg <= idle_cnt_reg + tmsv_pkg::IDLE_W'(1);
         end
      end else begin
         idle_cnt_reg <= '0;
         idle_reg     <= 1'b0;
      end
   end

   // busy from start to stop or silent idle
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         busy_reg <= 1'b0;
      end else if (start_det) begin
         busy_reg <= 1'b1;
      end else if (stop_det || idle_reg) begin
         busy_reg <= 1'b0;
      end
   end

   // clock-low timer, cleared while the line is high
   assign tif[tmsv_pkg::T_CLK_LOW].run   = I_CLK_LOW_EN && !scl_s_reg;
   assign tif[tmsv_pkg::T_CLK_LOW].clr   = scl_s_reg;
   assign tif[tmsv_pkg::T_CLK_LOW].limit = I_CLK_LOW_LIMIT;
   // arbitration timer only from a software start
   assign tif[tmsv_pkg::T_ARB].run       = arb_run_reg;
   assign tif[tmsv_pkg::T_ARB].clr       = I_SW_START;
   assign tif[tmsv_pkg::T_ARB].limit     = I_ARB_LIMIT;
   // byte timer, restarts at each byte boundary
   assign tif[tmsv_pkg::T_BYTE].run      = I_BYTE_EN && (I_MST_ACTIVE || I_SLV_ACTIVE);
   assign tif[tmsv_pkg::T_BYTE].clr      = I_BYTE_DONE || !(I_MST_ACTIVE || I_SLV_ACTIVE);
   assign tif[tmsv_pkg::T_BYTE].limit    = I_BYTE_LIMIT;
   assign tif[tmsv_pkg::T_TRANS].run     = I_TRANS_EN && busy_reg;
   assign tif[tmsv_pkg::T_TRANS].clr     = start_det || stop_det;
   assign tif[tmsv_pkg::T_TRANS].limit   = I_TRANS_LIMIT;
   assign tif[tmsv_pkg::T_BOOT].run      = I_BOOT_ACTIVE;
   assign tif[tmsv_pkg::T_BOOT].clr      = !I_BOOT_ACTIVE;
   assign tif[tmsv_pkg::T_BOOT].limit    = I_BOOT_DIAG_TIMER_COUNT;

   for (genvar g = 0; g < tmsv_pkg::TMR_NUM; g++) begin : g_tmr
      tmsv_timer #(.W(TW)) u_tmr (
         .i_clk   (I_CLK),
         .i_rst_b (I_RST_B),
         .tif     (tif[g].timer)
      );
      assign tmr_exp[g] = tif[g].expire;
   end

   // clock-low expiry outranks every other response except the boot stop
   assign clk_low_fire = tmr_exp[tmsv_pkg::T_CLK_LOW];

   // fire on expiry while idle-waiting or on a later collision
   assign arb_fire = (arb_pend_reg || tmr_exp[tmsv_pkg::T_ARB]) &&
                     (I_MST_WAIT_IDLE || I_ARB_COLLIDE) && !clk_low_fire;

   // arbitration window; a pending expiry waits for the address outcome
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         arb_run_reg  <= 1'b0;
         arb_pend_reg <= 1'b0;
      end else if (I_SW_START) begin
         arb_run_reg  <= 1'b1;
         arb_pend_reg <= 1'b0;
      end else if (arb_fire || clk_low_fire || I_MST_OWN_LOST) begin
         arb_run_reg  <= 1'b0;
         arb_pend_reg <= 1'b0;
      // clean address phase or an answered address ends it
      end else if (I_ADDR_PHASE_DONE || (arb_pend_reg && I_ADDR_ACK_RX)) begin
         arb_run_reg  <= 1'b0;
         arb_pend_reg <= 1'b0;
      end else if (tmr_exp[tmsv_pkg::T_ARB]) begin
         arb_pend_reg <= 1'b1;
      end
   end

   // expiry waits for the right bit; bit0 byte, bit1 transaction
   assign mst_fire = (|mst_pend_reg) && I_MST_DRIVE_BIT && !clk_low_fire;
   assign slv_fire = (|slv_pend_reg) && I_BIT_START && !clk_low_fire;

   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         mst_pend_reg <= 2'h0;
         slv_pend_reg <= 2'h0;
      end else begin
         if (mst_fire || clk_low_fire || !I_MST_ACTIVE) begin
            mst_pend_reg <= 2'h0;
         end else begin
            mst_pend_reg <= mst_pend_reg | {tmr_exp[tmsv_pkg::T_TRANS], tmr_exp[tmsv_pkg::T_BYTE]};
         end
         if (slv_fire || clk_low_fire || !I_SLV_ACTIVE) begin
            slv_pend_reg <= 2'h0;
         end else begin
            slv_pend_reg <= slv_pend_reg | {tmr_exp[tmsv_pkg::T_TRANS], tmr_exp[tmsv_pkg::T_BYTE]};
         end
      end
   end

   // boot expiry: next data byte, then stop
   assign boot_fire = boot_pend_reg && I_BOOT_BYTE_DONE;

   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         boot_pend_reg <= 1'b0;
         boot_cpl_reg  <= 1'b0;
      end else begin
         if (boot_fire || !I_BOOT_ACTIVE) begin
            boot_pend_reg <= 1'b0;
         end else if (tmr_exp[tmsv_pkg::T_BOOT]) begin
            boot_pend_reg <= 1'b1;
         end
         // complete on expiry or normal end; held until reset
         if (tmr_exp[tmsv_pkg::T_BOOT] || I_BOOT_DONE) begin
            boot_cpl_reg <= 1'b1;
         end
      end
   end

   // event pulses; clock-low with no engine sets none
   always_comb begin
      ev_next = tmsv_pkg::EV_RST;
      // slave takes precedence when both engines are busy
      ev_next[tmsv_pkg::EV_S_CLK]   = clk_low_fire && I_SLV_ACTIVE;
      ev_next[tmsv_pkg::EV_M_CLK]   = clk_low_fire && I_MST_ACTIVE && !I_SLV_ACTIVE;
      ev_next[tmsv_pkg::EV_M_ARB]   = arb_fire;
      ev_next[tmsv_pkg::EV_M_BYTE]  = mst_fire && mst_pend_reg[0];
      ev_next[tmsv_pkg::EV_M_TRANS] = mst_fire && mst_pend_reg[1];
      ev_next[tmsv_pkg::EV_S_BYTE]  = slv_fire && slv_pend_reg[0];
      ev_next[tmsv_pkg::EV_S_TRANS] = slv_fire && slv_pend_reg[1];
      ev_next[tmsv_pkg::EV_BOOT]    = boot_fire;
   end

   // events onto status groups
   always_comb begin
      hit = tmsv_pkg::STAT_RST;
      hit[tmsv_pkg::ST_SLV_FAIL] = ev_next[tmsv_pkg::EV_S_CLK] ||
                                   ev_next[tmsv_pkg::EV_S_BYTE] ||
                                   ev_next[tmsv_pkg::EV_S_TRANS];
      hit[tmsv_pkg::ST_MST_TMO]  = ev_next[tmsv_pkg::EV_M_CLK] ||
                                   ev_next[tmsv_pkg::EV_M_BYTE] ||
                                   ev_next[tmsv_pkg::EV_M_TRANS];
      hit[tmsv_pkg::ST_MST_ARB]  = ev_next[tmsv_pkg::EV_M_ARB];
      hit[tmsv_pkg::ST_BOOT]     = ev_next[tmsv_pkg::EV_BOOT];
   end

   // read moves new events to the snapshot; write-one clears only the
   // snapshot, so an event arriving with the clear survives in the new bits
   always_comb begin
      new_next  = (I_STAT_RD ? tmsv_pkg::STAT_RST : new_reg) | hit | I_STAT_SET;
      snap_next = (I_STAT_RD ? (snap_reg | new_reg) : snap_reg) & ~I_STAT_W1C;
   end

   // status; requests gated, status is not
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         new_reg  <= tmsv_pkg::STAT_RST;
         snap_reg <= tmsv_pkg::STAT_RST;
         stat_reg <= tmsv_pkg::STAT_RST;
         irq_reg  <= tmsv_pkg::STAT_RST;
      end else begin
         new_reg  <= new_next;
         snap_reg <= snap_next;
         stat_reg <= new_next | snap_next;
         irq_reg  <= (new_next | snap_next) & I_INT_EN;
      end
   end

   // requests to the engines, one cycle each
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         ev_reg        <= tmsv_pkg::EV_RST;
         abort_reg     <= 1'b0;
         stop_reg      <= 1'b0;
         retry_reg     <= 1'b0;
         slv_rel_reg   <= 1'b0;
         lines_rel_reg <= 1'b0;
         boot_stop_reg <= 1'b0;
      end else begin
         ev_reg        <= ev_next;
         abort_reg     <= arb_fire || I_MST_OWN_LOST || mst_fire || clk_low_fire;
         // no stop on clock-low; stop only after a driven bit
         stop_reg      <= mst_fire;
         // early collision: back to idle wait
         retry_reg     <= I_ARB_COLLIDE && arb_run_reg && !arb_fire && !clk_low_fire;
         // slave lets go at the next bit start
         slv_rel_reg   <= slv_fire;
         lines_rel_reg <= clk_low_fire;
         boot_stop_reg <= boot_fire;
      end
   end

   // outputs
   assign O_MST_ABORT                        = abort_reg;
   assign O_MST_STOP_REQ                     = stop_reg;
   assign O_MST_RETRY                        = retry_reg;
   assign O_SLV_RELEASE                      = slv_rel_reg;
   assign O_LINES_RELEASE                    = lines_rel_reg;
   assign O_BOOT_STOP_REQ                    = boot_stop_reg;
   assign O_BOOT_COMPLETE                    = boot_cpl_reg;
   assign O_BUS_IDLE                         = idle_reg;
   assign O_SLAVE_CLK_LOW_TIMEOUT_EVENT      = ev_reg[tmsv_pkg::EV_S_CLK];
   assign O_MASTER_CLK_LOW_TIMEOUT_EVENT     = ev_reg[tmsv_pkg::EV_M_CLK];
   assign O_MASTER_ARB_TIMEOUT_EVENT         = ev_reg[tmsv_pkg::EV_M_ARB];
   assign O_MASTER_BYTE_TIMEOUT_EVENT        = ev_reg[tmsv_pkg::EV_M_BYTE];
   assign O_SLAVE_BYTE_TIMEOUT_EVENT         = ev_reg[tmsv_pkg::EV_S_BYTE];
   assign O_MASTER_TRANSACTION_TIMEOUT_EVENT = ev_reg[tmsv_pkg::EV_M_TRANS];
   assign O_SLAVE_TRANSACTION_TIMEOUT_EVENT  = ev_reg[tmsv_pkg::EV_S_TRANS];
   assign O_BOOT_TIMEOUT_EVENT               = ev_reg[tmsv_pkg::EV_BOOT];
   assign O_SLAVE_ACCESS_FAIL_STATUS         = stat_reg[tmsv_pkg::ST_SLV_FAIL];
   assign O_MASTER_TIMEOUT_STATUS            = stat_reg[tmsv_pkg::ST_MST_TMO];
   assign O_MASTER_ARB_TIMEOUT_STATUS        = stat_reg[tmsv_pkg::ST_MST_ARB];
   assign O_BOOT_LOAD_FAIL_STATUS            = stat_reg[tmsv_pkg::ST_BOOT];
   assign O_IRQ                              = irq_reg;
endmodule

// ### tmsv_bus_model.sv
/* far side of the bus: other masters, slaves, boot memory.
   assumes i_run opens frames and i_hold_low sticks the clock. */
`timescale 1ns/10ps
module tmsv_bus_model (
   input  wire logic i_run,
   input  wire logic i_hold_low,
   output logic      o_scl,
   output logic      o_sda
);
   logic ph = 1'b1;
   // link clock of 400 ns, standing high between frames
   always #200 ph = i_run ? ~ph : 1'b1;
   // stuck participant wins the wired clock
   assign o_scl = i_hold_low ? 1'b0 : ph;
   // data moves only inside frames, pull-up level otherwise
   assign o_sda = i_run ? ~ph : 1'b1;
endmodule

// ### tmsv_checker.sv
/* assertions on the timeout responses.
   assumes a bind with ports matched by name. */
`timescale 1ns/10ps
module tmsv_checker (
   input wire logic I_CLK, I_RST_B, I_ARB_COLLIDE, I_MST_DRIVE_BIT, I_BIT_START,
   input wire logic I_BOOT_BYTE_DONE, O_MST_ABORT, O_MST_STOP_REQ, O_MST_RETRY,
   input wire logic O_SLV_RELEASE, O_LINES_RELEASE, O_BOOT_STOP_REQ, O_BOOT_COMPLETE,
   input wire logic O_SLAVE_CLK_LOW_TIMEOUT_EVENT, O_MASTER_CLK_LOW_TIMEOUT_EVENT,
   input wire logic O_MASTER_ARB_TIMEOUT_EVENT, O_MASTER_BYTE_TIMEOUT_EVENT,
   input wire logic O_SLAVE_BYTE_TIMEOUT_EVENT, O_BOOT_TIMEOUT_EVENT,
   input wire logic O_SLAVE_ACCESS_FAIL_STATUS, O_MASTER_TIMEOUT_STATUS,
   input wire logic O_MASTER_ARB_TIMEOUT_STATUS
);
   // one clock domain
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   a_slave_clk_low: assert property (O_SLAVE_CLK_LOW_TIMEOUT_EVENT |->
      O_LINES_RELEASE && O_MST_ABORT && O_SLAVE_ACCESS_FAIL_STATUS) else $error("slave low");
   a_master_clk_low: assert property (O_MASTER_CLK_LOW_TIMEOUT_EVENT |->
      O_LINES_RELEASE && !O_MST_STOP_REQ && O_MASTER_TIMEOUT_STATUS) else $error("master low");
   a_arb_abort: assert property (O_MASTER_ARB_TIMEOUT_EVENT |->
      O_MST_ABORT && O_MASTER_ARB_TIMEOUT_STATUS) else $error("arb abort");
   a_retry_collide: assert property (O_MST_RETRY |-> $past(I_ARB_COLLIDE))
      else $error("retry cause");
   a_mbyte_stop: assert property (O_MASTER_BYTE_TIMEOUT_EVENT |->
      O_MST_STOP_REQ && O_MST_ABORT && $past(I_MST_DRIVE_BIT)) else $error("byte stop");
   a_sbyte_release: assert property (O_SLAVE_BYTE_TIMEOUT_EVENT |->
      O_SLV_RELEASE && $past(I_BIT_START)) else $error("slave release");
   a_boot_stop: assert property (O_BOOT_TIMEOUT_EVENT |->
      O_BOOT_STOP_REQ && O_BOOT_COMPLETE && $past(I_BOOT_BYTE_DONE)) else $error("boot stop");
   a_boot_sticky: assert property (O_BOOT_COMPLETE |=> O_BOOT_COMPLETE)
      else $error("boot drop");
   // parked timer fires once
   a_event_once: assert property (O_MASTER_ARB_TIMEOUT_EVENT |=>
      !O_MASTER_ARB_TIMEOUT_EVENT [*3]) else $error("arb repeat");
endmodule
bind tmsv_supervisor tmsv_checker tmsv_checker_inst (.*);

// ### testbench.sv
/* self-checking bench for tmsv_supervisor.
   assumes the bus model and the bound checker. */
`timescale 1ns/10ps
module testbench;
   logic I_CLK = 1'b0, I_RST_B = 1'b0, run = 1'b0, hold = 1'b0, I_SCL, I_SERIAL_DATA_LINE;
   logic I_CLK_LOW_EN, I_BYTE_EN, I_TRANS_EN, I_MST_ACTIVE, I_SLV_ACTIVE, I_SW_START;
   logic I_ADDR_PHASE_DONE, I_ADDR_SENDING, I_ADDR_ACK_RX, I_ARB_COLLIDE, I_MST_WAIT_IDLE;
   logic I_MST_OWN_LOST, I_BYTE_DONE, I_MST_DRIVE_BIT, I_BIT_START, I_BOOT_ACTIVE;
   logic I_BOOT_DONE, I_BOOT_BYTE_DONE, I_STAT_RD, O_MST_ABORT, O_MST_STOP_REQ, O_MST_RETRY;
   logic [15:0] I_CLK_LOW_LIMIT, I_ARB_LIMIT, I_BYTE_LIMIT, I_TRANS_LIMIT, I_BOOT_DIAG_TIMER_COUNT;
   logic [3:0]  I_STAT_W1C, I_STAT_SET, I_INT_EN, O_IRQ, exp_st = 4'h0;
   logic O_SLV_RELEASE, O_LINES_RELEASE, O_BOOT_STOP_REQ, O_BOOT_COMPLETE, O_BUS_IDLE;
   logic O_SLAVE_CLK_LOW_TIMEOUT_EVENT, O_MASTER_CLK_LOW_TIMEOUT_EVENT, O_BOOT_TIMEOUT_EVENT;
   logic O_MASTER_ARB_TIMEOUT_EVENT, O_MASTER_BYTE_TIMEOUT_EVENT, O_SLAVE_BYTE_TIMEOUT_EVENT;
   logic O_MASTER_TRANSACTION_TIMEOUT_EVENT, O_SLAVE_TRANSACTION_TIMEOUT_EVENT;
   logic O_SLAVE_ACCESS_FAIL_STATUS, O_MASTER_TIMEOUT_STATUS, O_MASTER_ARB_TIMEOUT_STATUS;
   logic O_BOOT_LOAD_FAIL_STATUS;
   int          miscompares = 0, checks_done = 0, waited;
   int          grp[$] = '{0, 1, 2, 1, 0, 1, 0, 3}; // group per slot
   // events, status and requests in slot order
   wire [7:0] ev = {O_BOOT_TIMEOUT_EVENT, O_SLAVE_TRANSACTION_TIMEOUT_EVENT,
      O_MASTER_TRANSACTION_TIMEOUT_EVENT, O_SLAVE_BYTE_TIMEOUT_EVENT,
      O_MASTER_BYTE_TIMEOUT_EVENT, O_MASTER_ARB_TIMEOUT_EVENT,
      O_MASTER_CLK_LOW_TIMEOUT_EVENT, O_SLAVE_CLK_LOW_TIMEOUT_EVENT};
   wire [3:0] st = {O_BOOT_LOAD_FAIL_STATUS, O_MASTER_ARB_TIMEOUT_STATUS,
      O_MASTER_TIMEOUT_STATUS, O_SLAVE_ACCESS_FAIL_STATUS};
   wire [4:0] rq = {O_MST_ABORT, O_MST_STOP_REQ, O_SLV_RELEASE, O_LINES_RELEASE, O_BOOT_STOP_REQ};
   tmsv_supervisor tmsv_supervisor_inst (.*);
   tmsv_bus_model  tmsv_bus_model_inst (.i_run(run), .i_hold_low(hold), .o_scl(I_SCL),
      .o_sda(I_SERIAL_DATA_LINE));
   // 20 MHz core clock
   always #25 I_CLK = ~I_CLK;
   task chk(input logic [15:0] seen, input logic [15:0] want);
      checks_done++;
      if (seen !== want) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, want);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge I_CLK);
   endtask
   // bounded wait for an event, then compare with the model
   task expect_ev(input logic [7:0] e, input logic [4:0] r, input logic [4:0] m);
      waited = 0;
      #1;
      while (ev === 8'h00 && waited < 300) begin
         @(posedge I_CLK);
         #1;
         waited++;
      end
      for (int i = 0; i < 8; i++) if (e[i]) exp_st[grp[i]] = 1'b1;
      chk(ev, e);
      chk(rq & m, r);
      chk(O_IRQ, exp_st & I_INT_EN);
      @(posedge I_CLK);
      #1;
      chk(ev, 8'h00);
   endtask
   task wrap_up;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog: tests need under 2000 cycles
   initial begin
      #200000;
      miscompares++;
      wrap_up;
   end
   initial begin
      {I_CLK_LOW_EN, I_BYTE_EN, I_TRANS_EN, I_MST_ACTIVE, I_SLV_ACTIVE, I_SW_START,
         I_ADDR_PHASE_DONE, I_ADDR_SENDING, I_ADDR_ACK_RX, I_ARB_COLLIDE, I_MST_WAIT_IDLE,
         I_MST_OWN_LOST, I_BYTE_DONE, I_MST_DRIVE_BIT, I_BIT_START, I_BOOT_ACTIVE,
         I_BOOT_DONE, I_BOOT_BYTE_DONE, I_STAT_RD, I_STAT_W1C, I_STAT_SET} = '0;
      {I_CLK_LOW_LIMIT, I_ARB_LIMIT, I_BYTE_LIMIT, I_TRANS_LIMIT, I_BOOT_DIAG_TIMER_COUNT} = '0;
      void'($urandom(32'hc57b));
      I_INT_EN = 4'($urandom);
      tick(2);
      I_RST_B <= 1'b1;
      // stuck clock under slave, then master
      for (int i = 0; i < 2; i++) begin
         @(posedge I_CLK);
         {I_SLV_ACTIVE, I_MST_ACTIVE, I_CLK_LOW_EN} <= {i == 0, i == 1, 1'b1};
         I_CLK_LOW_LIMIT <= 16'(10 + $urandom % 40);
         hold <= 1'b1;
         expect_ev(8'(1 << i), 5'h12, 5'h1a);
         hold <= 1'b0;
      end
      I_MST_WAIT_IDLE <= 1'b1;
      tick(900);
      #1;
      chk(O_BUS_IDLE, 1'b0);
      tick(200);
      #1;
      chk(O_BUS_IDLE, 1'b1);
      $display("test 1 done");
      // collision retries; timer keeps running
      @(posedge I_CLK);
      {I_ARB_LIMIT, I_SW_START} <= {16'h0028, 1'b1};
      @(posedge I_CLK);
      I_SW_START <= 1'b0;
      tick(5);
      I_ARB_COLLIDE <= 1'b1;
      @(posedge I_CLK);
      I_ARB_COLLIDE <= 1'b0;
      #1;
      chk(O_MST_RETRY, 1'b1);
      expect_ev(8'h04, 5'h10, 5'h10);
      chk(waited < 38, 1'b1);
      $display("test 2 done");
      // byte expiry at next driven bit for master, then at next bit start for slave
      {I_BYTE_EN, I_BYTE_LIMIT, I_TRANS_EN, I_TRANS_LIMIT} <= {1'b1, 16'h000c, 1'b1, 16'hffff};
      for (int i = 0; i < 2; i++) begin
         @(posedge I_CLK);
         {I_SLV_ACTIVE, I_MST_ACTIVE, I_BYTE_DONE, run} <= {i == 1, i == 0, 2'b11};
         @(posedge I_CLK);
         I_BYTE_DONE <= 1'b0;
         tick(30);
         run <= 1'b0;
         #1;
         chk(ev, 8'h00);
         @(posedge I_CLK);
         {I_MST_DRIVE_BIT, I_BIT_START} <= {i == 0, i == 1};
         @(posedge I_CLK);
         {I_MST_DRIVE_BIT, I_BIT_START} <= 2'b00;
         expect_ev(i ? 8'h10 : 8'h08, i ? 5'h04 : 5'h18, i ? 5'h04 : 5'h18);
      end
      $display("test 3 done");
      // boot: zero count disables, small count fires
      for (int j = 0; j < 2; j++) begin
         @(posedge I_CLK);
         {I_BYTE_EN, I_MST_ACTIVE, I_SLV_ACTIVE, I_BOOT_ACTIVE} <= 4'h0;
         I_BOOT_DIAG_TIMER_COUNT <= j ? 16'h000f : 16'h0000;
         @(posedge I_CLK);
         I_BOOT_ACTIVE <= 1'b1;
         tick(30);
         I_BOOT_BYTE_DONE <= 1'b1;
         @(posedge I_CLK);
         I_BOOT_BYTE_DONE <= 1'b0;
         if (j) expect_ev(8'h80, 5'h01, 5'h01);
         #1;
         chk(ev, 8'h00);
         chk(O_BOOT_COMPLETE, j);
      end
      $display("test 4 done");
      // clear before read refused; test set forces one
      @(posedge I_CLK);
      I_STAT_W1C <= 4'hf;
      @(posedge I_CLK);
      {I_STAT_W1C, I_STAT_RD} <= {4'h0, 1'b1};
      @(posedge I_CLK);
      {I_STAT_RD, I_STAT_W1C} <= {1'b0, 4'hf};
      #1;
      chk(st, exp_st);
      @(posedge I_CLK);
      {I_STAT_W1C, I_STAT_SET} <= {4'h0, 4'h8};
      @(posedge I_CLK);
      I_STAT_SET <= 4'h0;
      tick(1);
      #1;
      chk(st, 4'h8);
      chk(O_IRQ, 4'h8 & I_INT_EN);
      $display("test 5 done");
      wrap_up;
   end
endmodule
